// file: verilog/key_encoder_pkg.sv
// constants shared by the keyboard key encoder
package key_encoder_pkg;
  localparam int CODE_W        = 5;
  localparam int BASE_KEYS     = 32;
  localparam int MAX_KEYS      = 61;
  localparam int MODE_SW       = 32;
  localparam int QUEUE_DEPTH   = 2;
  localparam int SETTLE_SCANS  = 3;
  localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
  localparam logic [1:0]        QCOUNT_RESET = 2'h0;
endpackage

// file: verilog/key_debounce.sv
// per-key sample-and-hold debouncer that flags settled press edges
`timescale 1ns/1ps
module key_debounce #(
  parameter int KEYS   = 32,
  parameter int SETTLE = 3
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // scan strobe and raw key levels
  input  wire logic            scanTick,
  input  wire logic [KEYS-1:0] keyRaw,
  // settled states and press events
  output logic      [KEYS-1:0] keyStable,
  output logic      [KEYS-1:0] keyPress
);
  localparam int CW = $clog2(SETTLE + 1);

  typedef struct packed {
    logic [KEYS-1:0]        held;
    logic [KEYS-1:0]        stable;
    logic [KEYS-1:0]        press;
    logic [KEYS*CW-1:0]     cnt;
  } db_state_t;

  db_state_t st_reg;
  db_state_t st_next;

  if (KEYS < 1) begin
    $error("key_debounce: KEYS must be at least 1");
  end
  if (SETTLE < 1) begin
    $error("key_debounce: SETTLE must be at least 1");
  end

  // a key only changes state after its sample held the same value for SETTLE scans
  always_comb begin
    st_next = st_reg;
    st_next.press = '0;
    if (scanTick) begin
      for (int k = 0; k < KEYS; k++) begin
        st_next.held[k] = keyRaw[k];
        if (keyRaw[k] != st_reg.held[k] || keyRaw[k] == st_reg.stable[k]) begin
          st_next.cnt[k*CW +: CW] = '0;
        end else if (st_reg.cnt[k*CW +: CW] == CW'(SETTLE - 1)) begin
          st_next.cnt[k*CW +: CW] = '0;
          st_next.stable[k] = keyRaw[k];
          st_next.press[k] = keyRaw[k];
        end else begin
          st_next.cnt[k*CW +: CW] = st_reg.cnt[k*CW +: CW] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign keyStable = st_reg.stable;
  assign keyPress  = st_reg.press;
endmodule

// file: verilog/keyboard_key_encoder.sv
// keyboard key encoder: debounce, press coding, two-entry queue, scan-line delivery
//
// Operation
// - each released-to-pressed key yields one 5-bit code unless the queue is full or a lower key settles in the same scan; held or released keys none.
// - codes wait inside until the deliver command moves one to the addressing register.
// - contact bounce rejected; only settled press transitions count as keystrokes.
// - new presses accepted while others held; two pending codes kept in order.
// - base encoder serves 32 keys; extension inputs 32-60 add keys whose 5-bit codes wrap onto those of keys 0-28.
// - combined interface debounces up to 61 keys and reads 32 mode switches.
// - codes travel to the timing unit on a dedicated serial scan line.
`timescale 1ns/1ps
module keyboard_key_encoder #(
  parameter int KEYS    = key_encoder_pkg::MAX_KEYS,
  parameter int MODES   = key_encoder_pkg::MODE_SW,
  parameter int SETTLE  = key_encoder_pkg::SETTLE_SCANS,
  parameter int SCANDIV = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // key matrix and mode switches, already scanned into levels
  input  wire logic [KEYS-1:0]  keyRaw,
  input  wire logic [MODES-1:0] modeSwitch,
  // program commands from the timing unit
  input  wire logic             deliverCmd,
  input  wire logic             storeModeSwitchesInstr,
  // keyboard scan line toward the timing unit
  output logic                  scanLine,
  output logic                  scanFrame,
  output logic                  scanDone,
  output logic [key_encoder_pkg::CODE_W-1:0] keyCode,
  output logic                  codeValid,
  // mode switch image
  output logic [MODES-1:0]      modeData,
  output logic                  modeValid,
  // status
  output logic                  keyPending,
  output logic                  queueFull,
  output logic                  pressDropped
);
  localparam int CW = key_encoder_pkg::CODE_W;
  localparam int QD = key_encoder_pkg::QUEUE_DEPTH;
  localparam int DW = $clog2(SCANDIV);
  localparam int BW = $clog2(CW + 1);

  // ==========================================================
  // elaboration checks
  if (KEYS < 1 || KEYS > key_encoder_pkg::MAX_KEYS) begin
    $error("keyboard_key_encoder: KEYS out of range");
  end
  if (MODES < 1 || MODES > key_encoder_pkg::MODE_SW) begin
    $error("keyboard_key_encoder: MODES out of range");
  end
  if (SCANDIV < 2) begin
    $error("keyboard_key_encoder: SCANDIV must be at least 2");
  end
  // the queue logic below is written for exactly two slots and a two-bit count
  if (QD != 2) begin
    $error("keyboard_key_encoder: queue depth must be 2");
  end

  // ==========================================================
  // state
  typedef enum logic [1:0] {IDLE, SHIFT, DONE} tx_state_t;

  // every register of the block outside u_debounce lives in one struct; st_next is its combinational image
  typedef struct packed {
    tx_state_t          tx;
    logic [DW-1:0]      div;
    logic [CW-1:0]      q0;
    logic [CW-1:0]      q1;
    logic [1:0]         qCount;
    logic [CW-1:0]      shiftReg;
    logic [BW-1:0]      bitCnt;
    logic               line;
    logic               frame;
    logic               done;
    logic [CW-1:0]      code;
    logic               valid;
    logic [MODES-1:0]   modes;
    logic               modesValid;
    logic               dropped;
  } enc_state_t;

  enc_state_t st_reg;
  enc_state_t st_next;

  logic            scanTick;
  logic [KEYS-1:0] keyPress;

  // ==========================================================
  // key scanning
  // keys are sampled only on scan ticks, so a bounce must outlast several ticks to pass
  assign scanTick = (st_reg.div == DW'(SCANDIV - 1));

  key_debounce #(
    .KEYS   (KEYS),
    .SETTLE (SETTLE)
  ) u_debounce (
    .clk       (clk),
    .srst      (srst),
    .scanTick  (scanTick),
    .keyRaw    (keyRaw),
    .keyStable (),
    .keyPress  (keyPress)
  );

  // ==========================================================
  // press priority
  // lowest-index press wins when several settle in one scan; the rest rescan no edge,
  // so simultaneous settles beyond the first are lost, a trade against a wider queue
  function automatic logic [CW:0] first_press(input logic [KEYS-1:0] p);
    logic [CW:0] r;
    r = '0;
    for (int k = KEYS - 1; k >= 0; k--) begin
      if (p[k]) begin
        r = {1'b1, CW'(k)};
      end
    end
    return r;
  endfunction

  logic [CW:0] hit;

  // ==========================================================
  // next state
  always_comb begin
    logic popNow;
    popNow  = 1'b0;
    hit     = first_press(keyPress);
    st_next = st_reg;
    st_next.done  = 1'b0;
    st_next.valid = 1'b0;
    st_next.div   = scanTick ? '0 : st_reg.div + DW'(1);
    st_next.dropped = 1'b0;

    // ==========================================================
    // serial delivery on the scan line
    unique case (st_reg.tx)
      IDLE: begin
        if (deliverCmd && st_reg.qCount != 2'h0) begin
          popNow           = 1'b1;
          st_next.shiftReg = st_reg.q0;
          st_next.bitCnt   = '0;
          st_next.frame    = 1'b1;
          st_next.line     = st_reg.q0[CW-1];
          st_next.tx       = SHIFT;
        end
      end
      SHIFT: begin
        // rotate rather than shift, so that after CW steps the register holds the whole code again
        if (st_reg.bitCnt == BW'(CW - 1)) begin
          st_next.shiftReg = {st_reg.shiftReg[CW-2:0], st_reg.shiftReg[CW-1]};
          st_next.frame    = 1'b0;
          st_next.line     = 1'b0;
          st_next.tx       = DONE;
        end else begin
          st_next.shiftReg = {st_reg.shiftReg[CW-2:0], st_reg.shiftReg[CW-1]};
          st_next.line     = st_reg.shiftReg[CW-2];
          st_next.bitCnt   = st_reg.bitCnt + BW'(1);
        end
      end
      DONE: begin
        // the parallel copy lands with the done pulse, one cycle after the frame closes
        st_next.done  = 1'b1;
        st_next.valid = 1'b1;
        st_next.code  = st_reg.shiftReg;
        st_next.tx    = IDLE;
      end
      default: st_next.tx = IDLE;
    endcase

    // ==========================================================
    // two-entry ordered queue; pop frees a slot in the same cycle a press arrives
    if (popNow) begin
      st_next.q0     = st_reg.q1;
      st_next.qCount = st_reg.qCount - 2'h1;
    end
    if (hit[CW]) begin
      if (st_next.qCount == 2'h0) begin
        st_next.q0     = hit[CW-1:0];
        st_next.qCount = 2'h1;
      end else if (st_next.qCount == 2'h1) begin
        st_next.q1     = hit[CW-1:0];
        st_next.qCount = 2'h2;
      end else begin
        // a full queue keeps its oldest codes; the newest press is the one lost
        st_next.dropped = 1'b1;
      end
    end

    // mode switch image for the timing unit's store instruction
    if (storeModeSwitchesInstr) begin
      st_next.modes      = modeSwitch;
      st_next.modesValid = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg        <= '0;
      st_reg.tx     <= IDLE;
      st_reg.q0     <= key_encoder_pkg::CODE_RESET;
      st_reg.q1     <= key_encoder_pkg::CODE_RESET;
      st_reg.code   <= key_encoder_pkg::CODE_RESET;
      st_reg.qCount <= key_encoder_pkg::QCOUNT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  // pending and full come straight from the count; data outputs and the drop flag are registered
  assign scanLine     = st_reg.line;
  assign scanFrame    = st_reg.frame;
  assign scanDone     = st_reg.done;
  assign keyCode      = st_reg.code;
  assign codeValid    = st_reg.valid;
  assign modeData     = st_reg.modes;
  assign modeValid    = st_reg.modesValid;
  assign keyPending   = (st_reg.qCount != 2'h0);
  assign queueFull    = (st_reg.qCount == 2'(QD));
  assign pressDropped = st_reg.dropped;
endmodule

// file: verification/key_encoder_sva.sv
// assertion checker for the keyboard key encoder
`timescale 1ns/1ps
module key_encoder_sva #(
  parameter int MODES = 32
) (
  // clock, reset and commands
  input  wire logic                               clk,
  input  wire logic                               srst,
  input  wire logic                               deliverCmd,
  input  wire logic                               storeModeSwitchesInstr,
  // scan line and status
  input  wire logic                               scanLine,
  input  wire logic                               scanFrame,
  input  wire logic                               scanDone,
  input  wire logic                               codeValid,
  input  wire logic                               modeValid,
  input  wire logic                               keyPending,
  input  wire logic                               queueFull,
  input  wire logic                               pressDropped,
  // mode switches and delivered code
  input  wire logic [MODES-1:0]                   modeSwitch,
  input  wire logic [MODES-1:0]                   modeData,
  input  wire logic [key_encoder_pkg::CODE_W-1:0] keyCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================
  // assertions
  a_frame_len: assert property ($rose(scanFrame) |-> scanFrame[*5] ##1 !scanFrame ##1 scanDone)
    else $error("scan frame length wrong");
  a_done_valid: assert property (scanDone == codeValid)
    else $error("done and valid disagree");
  a_deliver_cause: assert property ($rose(scanFrame) |-> $past(deliverCmd) && $past(keyPending))
    else $error("frame without command");
  a_code_serial: assert property (codeValid |-> keyCode == {$past(scanLine, 6), $past(scanLine, 5),
    $past(scanLine, 4), $past(scanLine, 3), $past(scanLine, 2)}) else $error("serial bits differ from code");
  a_code_hold: assert property (!codeValid |-> $stable(keyCode))
    else $error("code changed outside delivery");
  a_full_pending: assert property (queueFull |-> keyPending)
    else $error("full queue not pending");
  a_drop_full: assert property (pressDropped |-> $past(queueFull))
    else $error("press dropped with room left");
  a_mode_capture: assert property (storeModeSwitchesInstr |=> modeValid && modeData == $past(modeSwitch))
    else $error("mode switches not captured");
  c_frame: cover property ($rose(scanFrame));
  c_drop: cover property (pressDropped);
  c_mode: cover property ($rose(modeValid));
endmodule
bind keyboard_key_encoder key_encoder_sva #(.MODES(MODES)) u_sva (.clk(clk), .srst(srst), .deliverCmd(deliverCmd),
  .storeModeSwitchesInstr(storeModeSwitchesInstr), .scanLine(scanLine), .scanFrame(scanFrame), .scanDone(scanDone),
  .codeValid(codeValid), .modeValid(modeValid), .keyPending(keyPending), .queueFull(queueFull),
  .pressDropped(pressDropped), .modeSwitch(modeSwitch), .modeData(modeData), .keyCode(keyCode));

// file: verification/timing_unit_model.sv
// behavioural timing unit that pulls codes off the scan line
`timescale 1ns/1ps
module timing_unit_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // bench request and scan line
  input  wire logic wantCode,
  input  wire logic scanLine,
  input  wire logic scanFrame,
  input  wire logic scanDone,
  // command and addressing register
  output logic      deliverCmd,
  output logic [key_encoder_pkg::CODE_W-1:0] addrReg,
  output logic      gotCode
);
  logic [key_encoder_pkg::CODE_W-1:0] shiftReg;
  always @(posedge clk) begin
    gotCode <= 1'h0;
    if (srst) begin
      deliverCmd <= 1'h0;
      addrReg    <= 5'h00;
      shiftReg   <= 5'h00;
    end else begin
      // command stays up until the frame shows it was taken
      if (wantCode) deliverCmd <= 1'h1;
      if (scanFrame) begin
        deliverCmd <= 1'h0;
        shiftReg   <= {shiftReg[3:0], scanLine};
      end
      if (scanDone) begin
        addrReg <= shiftReg;
        gotCode <= 1'h1;
      end
    end
  end
endmodule

// file: verification/keyboard_key_encoder_tb_top.sv
// testbench for the keyboard key encoder
`timescale 1ns/1ps
module keyboard_key_encoder_tb_top;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic [60:0] keyRaw = '0;
  logic [31:0] modeSwitch = '0;
  logic        storeModeSwitchesInstr = 1'h0;
  logic        wantCode = 1'h0;
  logic        deliverCmd, scanLine, scanFrame, scanDone, codeValid, gotCode;
  logic        modeValid, keyPending, queueFull, pressDropped;
  logic [4:0]  keyCode, addrReg;
  logic [31:0] modeData;
  int          fails = 0;
  int          n_tests = 0;
  int          drops = 0;
  int          valids = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (pressDropped === 1'h1) drops++;
  always @(posedge clk) if (codeValid === 1'h1) valids++;
  keyboard_key_encoder dut (.clk(clk), .srst(srst), .keyRaw(keyRaw), .modeSwitch(modeSwitch),
    .deliverCmd(deliverCmd), .storeModeSwitchesInstr(storeModeSwitchesInstr), .scanLine(scanLine),
    .scanFrame(scanFrame), .scanDone(scanDone), .keyCode(keyCode), .codeValid(codeValid), .modeData(modeData),
    .modeValid(modeValid), .keyPending(keyPending), .queueFull(queueFull), .pressDropped(pressDropped));
  timing_unit_model far (.clk(clk), .srst(srst), .wantCode(wantCode), .scanLine(scanLine), .scanFrame(scanFrame),
    .scanDone(scanDone), .deliverCmd(deliverCmd), .addrReg(addrReg), .gotCode(gotCode));
  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one settle takes up to 16 clocks; 24 leaves margin
  task automatic key(input int k, input logic v);
    @(posedge clk) keyRaw[k] <= v;
    tick(24);
  endtask
  task automatic fetch(input logic [4:0] exp);
    int i;
    @(posedge clk) wantCode <= 1'h1;
    @(posedge clk) wantCode <= 1'h0;
    for (i = 0; i < 40 && gotCode !== 1'h1; i++) @(posedge clk);
    chk("addrReg", exp, addrReg);
    chk("keyCode", exp, keyCode);
    tick(2);
  endtask
  // ==========================================
  // scenarios
  task automatic t_bounce;
    int i;
    for (i = 0; i < 10; i++) begin
      @(posedge clk) keyRaw[3] <= ~i[0];
      tick(3);
    end
    tick(24);
    chk("keyPending", 0, keyPending);
  endtask
  task automatic t_queue;
    key(5, 1'h1);
    key(40, 1'h1);
    chk("queueFull", 1, queueFull);
    key(7, 1'h1);
    chk("drops", 1, drops);
    fetch(5'h05);
    fetch(5'h08);
    chk("codeValid", 2, valids);
    key(5, 1'h0);
    key(40, 1'h0);
    key(7, 1'h0);
    chk("keyPending", 0, keyPending);
  endtask
  task automatic t_modes;
    @(posedge clk) modeSwitch <= 32'ha5c30f96;
    storeModeSwitchesInstr <= 1'h1;
    @(posedge clk) storeModeSwitchesInstr <= 1'h0;
    tick(1);
    chk("modeData", 32'ha5c30f96, modeData);
    chk("modeValid", 1, modeValid);
  endtask
  // mid-run reset with a code queued and the key still held
  task automatic t_reset;
    key(9, 1'h1);
    chk("keyPending", 1, keyPending);
    @(posedge clk) srst <= 1'h1;
    tick(2);
    srst <= 1'h0;
    tick(1);
    chk("keyPending", 0, keyPending);
    chk("modeValid", 0, modeValid);
    key(9, 1'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tick(10);
    srst <= 1'h0;
    tick(2);
    t_bounce;
    t_queue;
    t_modes;
    t_reset;
    tally_and_finish;
  end
  initial begin
    tick(5000);
    fails++;
    tally_and_finish;
  end
endmodule
